// ---- rcl_pkg.sv ----
`default_nettype none
package rcl_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned N_LDO = 10;
  localparam int unsigned N_BUCK = 4;
  localparam int unsigned N_RES = 14;
  localparam int unsigned N_GPIO = 5;
  localparam int unsigned N_PIN = 7;
  localparam int unsigned N_SLOT = 15;
  localparam int unsigned RF_LDO_A = 4;
  localparam int unsigned RF_LDO_B = 5;
  localparam int unsigned SEL_MSB = 5;
  // Slot delays in ns as printed (30 us, 200 us, 500 us, 2 ms)
  localparam int unsigned SLOT_NS_0 = 30_000;
  localparam int unsigned SLOT_NS_1 = 200_000;
  localparam int unsigned SLOT_NS_2 = 500_000;
  localparam int unsigned SLOT_NS_3 = 2_000_000;
  localparam int unsigned NS_PER_CYC = 1_000_000_000 / CLK_HZ;
  localparam int unsigned SLOT_CYC_0 = SLOT_NS_0 / NS_PER_CYC;
  localparam int unsigned SLOT_CYC_1 = SLOT_NS_1 / NS_PER_CYC;
  localparam int unsigned SLOT_CYC_2 = SLOT_NS_2 / NS_PER_CYC;
  localparam int unsigned SLOT_CYC_3 = SLOT_NS_3 / NS_PER_CYC;
  // Register word byte addresses
  localparam logic [7:0] ADR_LDO_VSEL0 = 8'h00;
  localparam logic [7:0] ADR_LDO_CTRL = 8'h28;
  localparam logic [7:0] ADR_BUCK_CTRL = 8'h2C;
  localparam logic [7:0] ADR_SEQ_CTRL = 8'h30;
  localparam logic [7:0] ADR_SLOT0 = 8'h34;
  localparam logic [7:0] ADR_PINMAP0 = 8'h44;
  localparam logic [7:0] ADR_GPIO_CTRL = 8'h60;
  localparam logic [7:0] ADR_STATUS = 8'h64;
  localparam logic [7:0] ADR_SUPPLY_OK_STATUS = 8'h68;
  localparam logic [7:0] ADR_OUTS = 8'h6C;
  localparam logic [7:0] ADR_LDO_EN = 8'h70;
  localparam logic [7:0] ADR_BUCK_EN = 8'h74;
  // Field positions
  localparam int unsigned LC_ECO = 0;
  localparam int unsigned LC_PD = 10;
  localparam int unsigned BC_PWM = 0;
  localparam int unsigned BC_ECO = 4;
  localparam int unsigned BC_PD = 8;
  localparam int unsigned BC_RAMP = 12;
  localparam int unsigned BC_VMOVE = 13;
  localparam int unsigned SQ_LEN = 0;
  localparam int unsigned SQ_PWRON = 2;
  localparam int unsigned SQ_MASK = 3;
  localparam int unsigned GC_SPI = 0;
  localparam int unsigned GC_PP = 1;
  localparam int unsigned GC_OUT = 6;
  localparam int unsigned GC_OE = 11;
  localparam int unsigned GC_LED = 16;
  localparam logic [31:0] SLOT_RST = 32'h0000_0000;
  localparam logic [31:0] PINMAP_RST = 32'h0000_0000;
  localparam logic [31:0] ERR_DATA = 32'hDEAD_0000;
  typedef enum logic [1:0] {
    RCL_OFF = 2'b00,
    RCL_UP = 2'b01,
    RCL_ON = 2'b10,
    RCL_DOWN = 2'b11
  } rcl_seq_t;
endpackage : rcl_pkg
`default_nettype wire

// ---- rcl_top.sv ----
// Chosen here: the Wishbone slave port and the register addresses.
`default_nettype none
module rcl_top
  import rcl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [N_PIN-1:0] ctl_pins_i,
  input wire logic thermal_warn_i,
  input wire logic thermal_shutdown_i,
  input wire logic [N_LDO-1:0] linreg_cond_ok_i,
  input wire logic [N_LDO-1:0] linreg_cmp_ok_i,
  input wire logic [N_LDO-1:0] linreg_vin_low_i,
  input wire logic [N_BUCK-1:0] buck_cond_ok_i,
  input wire logic [N_BUCK-1:0] buck_above_90_i,
  input wire logic io_supply_uv_i,
  input wire logic [N_GPIO-1:0] gpio_in_i,
  output logic [N_LDO*6-1:0] linreg_vsel_o,
  output logic [N_LDO-1:0] linreg_en_o,
  output logic [N_LDO-1:0] linreg_lowq_o,
  output logic [N_LDO-1:0] linreg_pulldown_enable_o,
  output logic [N_BUCK-1:0] buck_en_o,
  output logic [N_BUCK-1:0] buck_forced_pwm_o,
  output logic [N_BUCK-1:0] buck_lowq_o,
  output logic [N_BUCK-1:0] buck_pulldown_enable_o,
  output logic [N_BUCK-1:0] buck_softstart_o,
  output logic buck_four_fast_ramp_o,
  output logic clk32_out_en_o,
  output logic [N_GPIO-1:0] gpio_o,
  output logic [N_GPIO-1:0] gpio_oe_o,
  output logic [2:0] led_sink_en_o,
  output logic irq_o,
  output logic dev_off_o
);

  localparam int unsigned SS_DLY = 16;
  localparam int unsigned SS_RAMP = 64;

  logic [31:0] vsel_ff [N_LDO];
  logic [31:0] lctl_ff, bctl_ff, seq_ff, gctl_ff;
  logic [31:0] slot_ff [4];
  logic [31:0] pmap_ff [N_PIN];
  logic [N_PIN-1:0] pin_s1_ff, pin_s2_ff;
  logic [2:0] th_s1_ff, th_s2_ff;
  logic [N_LDO-1:0] lcond_s1_ff, lcond_s2_ff, lcmp_s1_ff, lcmp_s2_ff, lvin_s1_ff, lvin_s2_ff;
  logic [N_BUCK-1:0] bcond_s1_ff, bcond_s2_ff, b90_s1_ff, b90_s2_ff;
  logic [N_GPIO-1:0] gin_s1_ff, gin_s2_ff;
  logic io_uv_s1_ff, io_uv_s2_ff;
  rcl_seq_t state_ff;
  logic [3:0] slot_ff_idx;
  logic [20:0] dly_ff;
  logic [N_RES+2+N_GPIO-1:0] seq_on_ff;
  logic [1:0] sticky_ff;
  logic [N_BUCK-1:0] ss_busy_ff;
  logic [7:0] ss_cnt_ff [N_BUCK];
  logic wb_hit;
  logic [20:0] slot_len;

  // Slot of resource r; slot 0 means pin-controlled only
  function automatic logic [3:0] res_slot(input int unsigned r);
    res_slot = slot_ff[r/8][(r%8)*4 +: 4];
  endfunction

  // Length of one slot in clock cycles
  function automatic logic [20:0] slot_cycles(input logic [1:0] sel);
    case (sel)
      2'b00: slot_cycles = 21'(SLOT_CYC_0);
      2'b01: slot_cycles = 21'(SLOT_CYC_1);
      2'b10: slot_cycles = 21'(SLOT_CYC_2);
      default: slot_cycles = 21'(SLOT_CYC_3);
    endcase
  endfunction

  assign slot_len = slot_cycles(seq_ff[SQ_LEN +: 2]);

  // Asynchronous pins and analog flags pass two flops
  always_ff @(posedge clk_i) begin
    pin_s1_ff <= ctl_pins_i;
    pin_s2_ff <= pin_s1_ff;
    th_s1_ff <= {thermal_shutdown_i, thermal_warn_i, io_supply_uv_i};
    th_s2_ff <= th_s1_ff;
    lcond_s1_ff <= linreg_cond_ok_i;
    lcond_s2_ff <= lcond_s1_ff;
    lcmp_s1_ff <= linreg_cmp_ok_i;
    lcmp_s2_ff <= lcmp_s1_ff;
    lvin_s1_ff <= linreg_vin_low_i;
    lvin_s2_ff <= lvin_s1_ff;
    bcond_s1_ff <= buck_cond_ok_i;
    bcond_s2_ff <= bcond_s1_ff;
    b90_s1_ff <= buck_above_90_i;
    b90_s2_ff <= b90_s1_ff;
    gin_s1_ff <= gpio_in_i;
    gin_s2_ff <= gin_s1_ff;
    io_uv_s1_ff <= io_supply_uv_i;
    io_uv_s2_ff <= io_uv_s1_ff;
  end

  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Register writes; byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N_LDO; i++) vsel_ff[i] <= 32'h0000_0000;
      lctl_ff <= 32'h0000_0000;
      bctl_ff <= 32'h0000_0000;
      seq_ff <= 32'h0000_0000;
      gctl_ff <= 32'h0000_0000;
      for (int i = 0; i < 4; i++) slot_ff[i] <= SLOT_RST;
      for (int i = 0; i < N_PIN; i++) pmap_ff[i] <= PINMAP_RST;
    end else if (wb_hit && wb_we_i) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          for (int i = 0; i < N_LDO; i++) begin
            if (wb_adr_i == ADR_LDO_VSEL0 + 8'(4*i)) vsel_ff[i][8*b +: 8] <= wb_dat_i[8*b +: 8];
          end
          for (int i = 0; i < 4; i++) begin
            if (wb_adr_i == ADR_SLOT0 + 8'(4*i)) slot_ff[i][8*b +: 8] <= wb_dat_i[8*b +: 8];
          end
          for (int i = 0; i < N_PIN; i++) begin
            if (wb_adr_i == ADR_PINMAP0 + 8'(4*i)) pmap_ff[i][8*b +: 8] <= wb_dat_i[8*b +: 8];
          end
          if (wb_adr_i == ADR_LDO_CTRL) lctl_ff[8*b +: 8] <= wb_dat_i[8*b +: 8];
          if (wb_adr_i == ADR_BUCK_CTRL) bctl_ff[8*b +: 8] <= wb_dat_i[8*b +: 8];
          if (wb_adr_i == ADR_SEQ_CTRL) seq_ff[8*b +: 8] <= wb_dat_i[8*b +: 8];
          if (wb_adr_i == ADR_GPIO_CTRL) gctl_ff[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end

  // Power sequencer: up walks slots 1..15, down walks from the current slot back to 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= RCL_OFF;
      slot_ff_idx <= 4'h0;
      dly_ff <= 21'h00_0000;
    end else if (th_s2_ff[2]) begin
      state_ff <= RCL_OFF;
      slot_ff_idx <= 4'h0;
      dly_ff <= 21'h00_0000;
    end else begin
      case (state_ff)
        RCL_OFF: begin
          if (seq_ff[SQ_PWRON]) begin
            state_ff <= RCL_UP;
            slot_ff_idx <= 4'h1;
            dly_ff <= slot_len;
          end
        end
        RCL_UP: begin
          if (!seq_ff[SQ_PWRON]) begin
            state_ff <= RCL_DOWN;
            dly_ff <= slot_len;
          end else if (dly_ff != 21'h00_0000) begin
            dly_ff <= dly_ff - 21'h00_0001;
          end else if (slot_ff_idx == 4'(N_SLOT)) begin
            state_ff <= RCL_ON;
          end else begin
            slot_ff_idx <= slot_ff_idx + 4'h1;
            dly_ff <= slot_len;
          end
        end
        RCL_ON: begin
          if (!seq_ff[SQ_PWRON]) begin
            state_ff <= RCL_DOWN;
            dly_ff <= slot_len;
          end
        end
        RCL_DOWN: begin
          if (dly_ff != 21'h00_0000) begin
            dly_ff <= dly_ff - 21'h00_0001;
          end else if (slot_ff_idx <= 4'h1) begin
            state_ff <= RCL_OFF;
            slot_ff_idx <= 4'h0;
          end else begin
            slot_ff_idx <= slot_ff_idx - 4'h1;
            dly_ff <= slot_len;
          end
        end
        default: state_ff <= RCL_OFF;
      endcase
    end
  end

  // Resources 0..9 linear, 10..13 converters, 14 clock out, 15 unused, 16..20 GPIO
  always_ff @(posedge clk_i) begin
    if (rst_i || th_s2_ff[2]) begin
      seq_on_ff <= '0;
    end else begin
      for (int r = 0; r < N_RES + 2 + N_GPIO; r++) begin
        logic pin_on;
        logic [3:0] s;
        pin_on = 1'b0;
        s = res_slot(r);
        for (int p = 0; p < N_PIN; p++) begin
          if (pmap_ff[p][r] && pin_s2_ff[p]) pin_on = 1'b1;
        end
        if (s == 4'h0) seq_on_ff[r] <= pin_on;
        else seq_on_ff[r] <= pin_on || (state_ff != RCL_OFF && slot_ff_idx >= s && s != 4'h0);
      end
    end
  end

  // Soft start: delay then ramp, faster for converter four
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ss_busy_ff <= '0;
      for (int i = 0; i < N_BUCK; i++) ss_cnt_ff[i] <= 8'h00;
    end else begin
      for (int i = 0; i < N_BUCK; i++) begin
        if (!seq_on_ff[N_LDO+i]) begin
          ss_busy_ff[i] <= 1'b0;
          ss_cnt_ff[i] <= 8'h00;
        end else if (ss_cnt_ff[i] != 8'hFF) begin
          ss_cnt_ff[i] <= ss_cnt_ff[i] + ((i == 3 && bctl_ff[BC_RAMP]) ? 8'h02 : 8'h01);
          ss_busy_ff[i] <= (ss_cnt_ff[i] >= 8'(SS_DLY)) && (ss_cnt_ff[i] < 8'(SS_DLY + SS_RAMP));
        end else begin
          ss_busy_ff[i] <= 1'b0;
        end
      end
    end
  end

  // Sticky events: overheat warning and converter power loss; write 1 to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sticky_ff <= 2'b00;
    end else begin
      for (int k = 0; k < 2; k++) begin
        logic ev;
        // Only an enabled, unblanked converter with buck_above_90_i high counts as a fault
        ev = (k == 0) ? th_s2_ff[1]
                      : |(seq_on_ff[N_RES-1:N_LDO] & ~ss_busy_ff & ~bctl_ff[BC_VMOVE +: N_BUCK] & b90_s2_ff);
        if (ev) sticky_ff[k] <= 1'b1;
        else if (wb_hit && wb_we_i && wb_adr_i == ADR_STATUS && wb_sel_i[0] && wb_dat_i[k]) sticky_ff[k] <= 1'b0;
      end
    end
  end

  // Converter supply ok, blanked while off, ramping or moving
  function automatic logic [N_BUCK-1:0] buck_supply_ok_status();
    for (int i = 0; i < N_BUCK; i++) begin
      buck_supply_ok_status[i] = seq_on_ff[N_LDO+i] && !ss_busy_ff[i] && !bctl_ff[BC_VMOVE+i] && !b90_s2_ff[i];
    end
  endfunction

  // Outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      linreg_vsel_o <= '0;
      linreg_en_o <= '0;
      linreg_lowq_o <= '0;
      linreg_pulldown_enable_o <= '0;
      buck_en_o <= '0;
      buck_forced_pwm_o <= '0;
      buck_lowq_o <= '0;
      buck_pulldown_enable_o <= '0;
      buck_softstart_o <= '0;
      buck_four_fast_ramp_o <= 1'b0;
      clk32_out_en_o <= 1'b0;
      gpio_o <= '0;
      gpio_oe_o <= '0;
      led_sink_en_o <= 3'b000;
      irq_o <= 1'b0;
      dev_off_o <= 1'b1;
    end else begin
      for (int i = 0; i < N_LDO; i++) begin
        linreg_vsel_o[6*i +: 6] <= vsel_ff[i][5:0];
        if (i == RF_LDO_A || i == RF_LDO_B) linreg_vsel_o[6*i+SEL_MSB] <= 1'b1;
        linreg_en_o[i] <= seq_on_ff[i];
        linreg_lowq_o[i] <= lctl_ff[LC_ECO+i] && lcond_s2_ff[i];
        linreg_pulldown_enable_o[i] <= lctl_ff[LC_PD+i] && !seq_on_ff[i];
      end
      for (int i = 0; i < N_BUCK; i++) begin
        buck_en_o[i] <= seq_on_ff[N_LDO+i];
        buck_forced_pwm_o[i] <= bctl_ff[BC_PWM+i];
        buck_lowq_o[i] <= bctl_ff[BC_ECO+i] && bcond_s2_ff[i] && !bctl_ff[BC_PWM+i];
        buck_pulldown_enable_o[i] <= bctl_ff[BC_PD+i] && !seq_on_ff[N_LDO+i];
        buck_softstart_o[i] <= ss_busy_ff[i];
      end
      buck_four_fast_ramp_o <= bctl_ff[BC_RAMP];
      clk32_out_en_o <= seq_on_ff[N_RES];
      for (int g = 0; g < N_GPIO; g++) begin
        logic drive;
        logic level;
        level = gctl_ff[GC_OUT+g] || seq_on_ff[N_RES+2+g];
        drive = gctl_ff[GC_OE+g] || seq_on_ff[N_RES+2+g];
        if (g < 2 && gctl_ff[GC_SPI]) drive = 1'b0;
        if (g >= 2 && gctl_ff[GC_LED+g-2]) drive = 1'b0;
        // Undervoltage or open-drain: drive low only, release for high
        if ((!gctl_ff[GC_PP+g] || io_uv_s2_ff) && level) drive = 1'b0;
        gpio_o[g] <= level;
        gpio_oe_o[g] <= drive;
      end
      for (int j = 0; j < 3; j++) led_sink_en_o[j] <= gctl_ff[GC_LED+j];
      irq_o <= (sticky_ff[0] && !seq_ff[SQ_MASK]) || (sticky_ff[1] && !seq_ff[SQ_MASK+1]);
      dev_off_o <= (state_ff == RCL_OFF);
    end
  end

  // Wishbone answer: one wait cycle, unmapped reads give a fixed pattern
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= ERR_DATA;
      for (int i = 0; i < N_LDO; i++) if (wb_adr_i == ADR_LDO_VSEL0 + 8'(4*i)) wb_dat_o <= vsel_ff[i];
      for (int i = 0; i < 4; i++) if (wb_adr_i == ADR_SLOT0 + 8'(4*i)) wb_dat_o <= slot_ff[i];
      for (int i = 0; i < N_PIN; i++) if (wb_adr_i == ADR_PINMAP0 + 8'(4*i)) wb_dat_o <= pmap_ff[i];
      case (wb_adr_i)
        ADR_LDO_CTRL: wb_dat_o <= lctl_ff;
        ADR_BUCK_CTRL: wb_dat_o <= bctl_ff;
        ADR_SEQ_CTRL: wb_dat_o <= seq_ff;
        ADR_GPIO_CTRL: wb_dat_o <= {27'h000_0000, gin_s2_ff};
        ADR_STATUS: wb_dat_o <= {26'h000_0000, state_ff, th_s2_ff[2:1], sticky_ff};
        ADR_SUPPLY_OK_STATUS: wb_dat_o <= {18'h0_0000, buck_supply_ok_status(), lcmp_s2_ff & ~(seq_on_ff[N_LDO-1:0] & lvin_s2_ff)};
        ADR_OUTS: wb_dat_o <= {28'h000_0000, slot_ff_idx};
        ADR_LDO_EN: wb_dat_o <= {22'h00_0000, seq_on_ff[N_LDO-1:0]};
        ADR_BUCK_EN: wb_dat_o <= {28'h000_0000, seq_on_ff[N_RES-1:N_LDO]};
        default: ;
      endcase
    end
  end

endmodule // rcl_top
`default_nettype wire

// ---- rcl_checker.sv ----
`default_nettype none
module rcl_checker
  import rcl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic thermal_shutdown_i,
  input wire logic [N_LDO-1:0] linreg_cond_ok_i,
  input wire logic [N_LDO*6-1:0] linreg_vsel_o,
  input wire logic [N_LDO-1:0] linreg_en_o,
  input wire logic [N_LDO-1:0] linreg_lowq_o,
  input wire logic [N_LDO-1:0] linreg_pulldown_enable_o,
  input wire logic [N_BUCK-1:0] buck_en_o,
  input wire logic [N_BUCK-1:0] buck_forced_pwm_o,
  input wire logic [N_BUCK-1:0] buck_lowq_o,
  input wire logic [N_BUCK-1:0] buck_pulldown_enable_o,
  input wire logic irq_o,
  input wire logic dev_off_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered on next cycle");
  a_err_data: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) >= 8'h78 |-> wb_dat_o == ERR_DATA)
    else $error("unmapped read data wrong");
  // One clean cycle after reset before the registered select shows the forced bit; the check waits for two
  a_rf_top_bit: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
    linreg_vsel_o[6*RF_LDO_A+SEL_MSB] && linreg_vsel_o[6*RF_LDO_B+SEL_MSB])
    else $error("RF select top bit not forced");
  a_lin_pd_gate: assert property ((linreg_pulldown_enable_o & linreg_en_o & $past(linreg_en_o)) == '0)
    else $error("linear pulldown on while enabled");
  a_buck_pd_gate: assert property ((buck_pulldown_enable_o & buck_en_o & $past(buck_en_o)) == '0)
    else $error("converter pulldown on while enabled");
  a_pwm_no_lowq: assert property ((buck_lowq_o & buck_forced_pwm_o) == '0)
    else $error("low quiescent with forced pwm");
  // Condition passes two sync flops plus one output flop; one extra cycle of slack
  a_lowq_cond: assert property ((linreg_lowq_o & ~$past(linreg_cond_ok_i, 3) & ~$past(linreg_cond_ok_i, 4)) == '0)
    else $error("linear low quiescent without condition");
  a_shutdown_off: assert property ($rose(thermal_shutdown_i) |->
    ##[1:8] (dev_off_o && linreg_en_o == '0 && buck_en_o == '0))
    else $error("shutdown did not power down");
  c_ack: cover property (wb_ack_o);
  c_irq: cover property (irq_o);
  c_lowq: cover property (|buck_lowq_o);
  c_on: cover property ($fell(dev_off_o));
endmodule // rcl_checker
bind rcl_top rcl_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .thermal_shutdown_i(thermal_shutdown_i), .linreg_cond_ok_i(linreg_cond_ok_i), .linreg_vsel_o(linreg_vsel_o),
  .linreg_en_o(linreg_en_o), .linreg_lowq_o(linreg_lowq_o), .linreg_pulldown_enable_o(linreg_pulldown_enable_o),
  .buck_en_o(buck_en_o), .buck_forced_pwm_o(buck_forced_pwm_o), .buck_lowq_o(buck_lowq_o),
  .buck_pulldown_enable_o(buck_pulldown_enable_o), .irq_o(irq_o), .dev_off_o(dev_off_o));
`default_nettype wire

// ---- rcl_host_model.sv ----
`default_nettype none
module rcl_host_model (
  input wire logic clk_i,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [31:0] wb_dat_o,
  output logic [3:0] wb_sel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned tmo_cnt = 0;
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_dat_o = 32'h0000_0000;
    wb_sel_o = 4'h0;
  end
  // Idle address and data lines show inverted values so a stale sample is never mistaken for a live one
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_dat_o <= d;
    wb_sel_o <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_i !== 1'b1 && n < 64);
    if (wb_ack_i !== 1'b1) tmo_cnt++;
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    wb_adr_o <= ~a;
    wb_dat_o <= ~d;
  endtask
endmodule // rcl_host_model
`default_nettype wire

// ---- tb_regulator_control_logic.sv ----
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_regulator_control_logic
  import rcl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, warn = 1'b0, tsd = 1'b0, uv = 1'b0, fast, irq, off, clk32;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, v, q;
  logic [3:0] sel;
  logic [N_PIN-1:0] pins = '0;
  logic [N_LDO-1:0] lcond = '0, lcmp = '0, lvin = '0, len, llq, lpd;
  logic [N_BUCK-1:0] bcond = '0, b90 = '0, ben, bpwm, blq, bpd, bss;
  logic [N_GPIO-1:0] gin = '0, gout, goe;
  logic [N_LDO*6-1:0] vsel;
  logic [2:0] led;
  logic [5:0] ev [N_LDO];
  int failures = 0;
  int n_tests = 0;
  int seed = 22536;
  int c;
  rcl_host_model host (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc), .wb_stb_o(stb),
    .wb_we_o(we), .wb_adr_o(adr), .wb_dat_o(wdat), .wb_sel_o(sel));
  rcl_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .ctl_pins_i(pins), .thermal_warn_i(warn),
    .thermal_shutdown_i(tsd), .linreg_cond_ok_i(lcond), .linreg_cmp_ok_i(lcmp), .linreg_vin_low_i(lvin),
    .buck_cond_ok_i(bcond), .buck_above_90_i(b90), .io_supply_uv_i(uv), .gpio_in_i(gin),
    .linreg_vsel_o(vsel), .linreg_en_o(len), .linreg_lowq_o(llq), .linreg_pulldown_enable_o(lpd),
    .buck_en_o(ben), .buck_forced_pwm_o(bpwm), .buck_lowq_o(blq), .buck_pulldown_enable_o(bpd),
    .buck_softstart_o(bss), .buck_four_fast_ramp_o(fast), .clk32_out_en_o(clk32), .gpio_o(gout), .gpio_oe_o(goe),
    .led_sink_en_o(led), .irq_o(irq), .dev_off_o(off));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [5:0] vsel_exp(input int i, input logic [5:0] s);
    return (i == RF_LDO_A || i == RF_LDO_B) ? (s | 6'h20) : s;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    host.xfer(1'b1, a, d, r);
    if (host.tmo_cnt != 0) wrap_up();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    host.xfer(1'b0, a, 32'h0000_0000, r);
    if (host.tmo_cnt != 0) wrap_up();
  endtask
  task automatic wrap_up();
    failures += host.tmo_cnt;
    $display("Comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Slot waits can reach two slot lengths, hence the wide bound
  task automatic wait_en(input int i, input logic val, output int n);
    n = 0;
    while (len[i] !== val && n < 7000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 7000) begin
      failures++;
      wrap_up();
    end
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    wrap_up();
  end
  initial begin
    tick(6);
    rst_i <= 1'b0;
    lcmp <= 10'($random(seed));
    lvin <= 10'($random(seed));
    gin <= 5'($random(seed));
    b90 <= 4'($random(seed));
    tick(2);
    `CHK("dev_off", 1'b1, off)
    `CHK("rails", 14'h0000, {len, ben})
    for (int i = 0; i < N_LDO; i++) begin
      v = $random(seed) & 32'h0000_003F;
      ev[i] = vsel_exp(i, v[5:0]);
      wr(8'(4 * i), v);
    end
    rd(8'h78, q);
    `CHK("unmapped", ERR_DATA, q)
    rd(8'h0C, q);
    `CHK("vsel_rd", {26'h0, ev[3]}, q)
    tick(4);
    for (int i = 0; i < N_LDO; i++) `CHK("vsel", ev[i], vsel[6*i+:6])
    wr(ADR_SLOT0, 32'h0000_0021);
    wr(ADR_SEQ_CTRL, 32'h0000_0004);
    wait_en(0, 1'b1, c);
    wait_en(1, 1'b1, c);
    `CHK("slot_len", 1'b1, c >= 2990 && c <= 3010)
    wr(ADR_LDO_VSEL0, 32'h0000_0011);
    tick(4);
    `CHK("vsel_live", 6'h11, vsel[5:0])
    lcond <= 10'h001;
    wr(ADR_LDO_CTRL, 32'h0000_1805);
    tick(6);
    `CHK("lin_lowq", 10'h001, llq)
    `CHK("lin_pd", 10'h004, lpd)
    wr(8'h50, 32'h0000_0004);
    pins <= 7'h08;
    tick(8);
    `CHK("pin_en", 1'b1, len[2])
    pins <= '0;
    tick(8);
    `CHK("pin_dis", 1'b0, len[2])
    for (int k = 0; k < 8; k++) begin
      v = (k == 0) ? 32'h0000_10F0 : (k == 1) ? 32'h0000_0FFF : $random(seed) & 32'h0000_1FFF;
      bcond <= (k < 2) ? 4'hF : 4'($random(seed));
      wr(ADR_BUCK_CTRL, v);
      tick(6);
      `CHK("pwm", v[3:0], bpwm)
      `CHK("buck_lowq", v[7:4] & ~v[3:0] & bcond, blq)
      `CHK("buck_pd", v[11:8], bpd)
      `CHK("fast", v[12], fast)
    end
    wr(ADR_BUCK_CTRL, 32'h0000_0000);
    warn <= 1'b1;
    tick(8);
    `CHK("irq_on", 1'b1, irq)
    warn <= 1'b0;
    tick(6);
    wr(ADR_STATUS, 32'h0000_0001);
    wr(ADR_SEQ_CTRL, 32'h0000_000C);
    warn <= 1'b1;
    tick(8);
    `CHK("irq_masked", 1'b0, irq)
    warn <= 1'b0;
    tick(6);
    wr(ADR_STATUS, 32'h0000_0001);
    wr(ADR_SEQ_CTRL, 32'h0000_0008);
    wait_en(1, 1'b0, c);
    `CHK("down_order", 1'b1, len[0])
    wait_en(0, 1'b0, c);
    `CHK("down_len", 1'b1, c >= 2990 && c <= 3010)
    wr(ADR_SEQ_CTRL, 32'h0000_000C);
    wait_en(0, 1'b1, c);
    tsd <= 1'b1;
    tick(8);
    `CHK("tsd", 15'h4000, {off, len, ben})
    tsd <= 1'b0;
    wr(ADR_SEQ_CTRL, 32'h0000_0008);
    wr(ADR_GPIO_CTRL, 32'h0000_FFFE);
    tick(6);
    `CHK("gpio_pp", 10'h3FF, {goe, gout})
    uv <= 1'b1;
    tick(8);
    `CHK("gpio_uv", 5'h00, goe)
    uv <= 1'b0;
    wr(ADR_GPIO_CTRL, 32'h0005_FFFF);
    tick(6);
    `CHK("gpio_spi", 2'b00, goe[1:0])
    `CHK("led", 3'b101, led)
    b90 <= 4'h0;
    wr(ADR_PINMAP0, 32'h0000_4404);
    pins <= 7'h01;
    tick(30);
    `CHK("softstart", 4'h1, bss)
    tick(300);
    `CHK("clk32", 1'b1, clk32)
    `CHK("ss_done", 4'h0, bss)
    `CHK("irq_good", 1'b0, irq)
    rd(ADR_SUPPLY_OK_STATUS, q);
    `CHK("supply_ok_status", {18'h0_0000, 4'h1, lcmp & ~(10'h004 & lvin)}, q)
    b90 <= 4'h1;
    tick(8);
    `CHK("irq_fault", 1'b1, irq)
    rd(ADR_SUPPLY_OK_STATUS, q);
    `CHK("supply_ok_status_low", 4'h0, q[13:10])
    b90 <= 4'h0;
    wr(ADR_BUCK_CTRL, 32'h0000_2000);
    tick(6);
    rd(ADR_SUPPLY_OK_STATUS, q);
    `CHK("supply_ok_status_blank", 4'h0, q[13:10])
    wrap_up();
  end
endmodule // tb_regulator_control_logic
`default_nettype wire
